// >>> design/wdtc_pkg.sv
// Purpose: shared constants and types of the watchdog timeout counter
// Assumes: one clock, the oscillator clock, at 100 MHz
// Notes:   register byte addresses are word aligned on AHB-Lite
`default_nettype none
package wdtc_pkg;
    // service location printed as an index; its byte address is four times it
    localparam logic [17:0] SERVICE_IDX      = 18'h0ffff;
    localparam logic [19:0] ADDR_SERVICE     = 20'(SERVICE_IDX * 4);
    localparam logic [19:0] ADDR_CAUSE       = 20'h00000;
    localparam logic [19:0] ADDR_IRQ_STATUS  = 20'h00004;
    localparam logic [19:0] ADDR_IRQ_MASK    = 20'h00008;
    localparam logic [19:0] ADDR_COUNT       = 20'h0000c;
    localparam int          ADDR_W           = 20;

    localparam int          PRE_W            = 12;
    localparam int          WD_W             = 6;
    localparam int          SVC_CLR_LO       = 4;
    localparam int          SVC_CLR_HI       = 11;
    localparam logic [17:0] LONG_TIMEOUT     = 18'h3fff0;
    localparam logic [17:0] SHORT_TIMEOUT    = 18'h01ff0;
    localparam logic [12:0] SHORT_MASK_W     = 13'h1fff;
    localparam int          RST_PULSE_CYC    = 32;
    localparam int          POR_CYC          = 4096;

    // bit positions in cause, status and mask registers
    localparam int          BIT_TIMEOUT      = 0;
    localparam int          BIT_SERVICE      = 1;
    localparam logic [1:0]  EVT_RESET        = 2'h0;
    localparam logic [1:0]  MASK_RESET       = 2'h0;
    localparam logic [7:0]  VECTOR_LO_DFLT   = 8'h00;

    localparam logic [1:0]  HTRANS_NONSEQ    = 2'h2;
    localparam logic [1:0]  HTRANS_SEQ       = 2'h3;

    typedef enum logic [1:0] {
        WDTC_ST_POR   = 2'h0,
        WDTC_ST_RUN   = 2'h1,
        WDTC_ST_PULSE = 2'h3
    } wdtc_state_t;

    typedef struct packed {
        logic              valid;
        logic              write;
        logic [ADDR_W-1:0] addr;
    } wdtc_aphase_t;
endpackage : wdtc_pkg
`default_nettype wire

// >>> design/wdtc_top.sv
// Purpose: watchdog timeout counter with an AHB-Lite register slave
// Assumes: the oscillator clock is core_clk_in; test-voltage and mode pins are asynchronous
// Notes:   zero wait state slave, always OKAY
//
// Overview of operation
// R1: an 18-bit chain counts oscillator cycles: a 12-bit prescaler whose carry steps a 6-bit watchdog counter.
// R2: without service the chain times out after 262128 cycles, or 8176 when the rate select is high.
// R3: any write to the service location clears the watchdog counter and prescaler bits 11 to 4.
// R4: a read of the service location returns the low byte of the reset vector.
// R5: a timeout drives the reset pin low for 32 cycles and sets the watchdog cause flag.
// R6: counting and timeout are held off in monitor state with either test voltage, or in break state with the reset-pin test voltage.
// R7: the stop instruction clears the prescaler.
// R8: 4096 cycles after power-up the prescaler is cleared.
// R9: any internal reset clears prescaler and watchdog counter.
// R10: the counter runs on the oscillator clock itself, one step a cycle.
// R11: software should service right after reset and around stop mode to get the full timeout.
// R12: the rate select only picks the terminal count and never touches the count.
//
// Added by the designer: the AHB-Lite interface to the registers.
`default_nettype none
module wdtc_top #(
    parameter int         POR_CYCLES = wdtc_pkg::POR_CYC,
    parameter logic [7:0] VECTOR_LO  = wdtc_pkg::VECTOR_LO_DFLT
) (
    input  wire logic        core_clk_in,
    input  wire logic        arst_n_in,
    input  wire logic        hsel_in,
    input  wire logic [31:0] haddr_in,
    input  wire logic [1:0]  htrans_in,
    input  wire logic        hwrite_in,
    input  wire logic [2:0]  hsize_in,
    input  wire logic [31:0] hwdata_in,
    input  wire logic        hready_in,
    output logic      [31:0] hrdata_out,
    output logic             hreadyout_out,
    output logic             hresp_out,
    input  wire logic        timeout_rate_select_in,
    input  wire logic        monitor_mode_in,
    input  wire logic        break_state_in,
    input  wire logic        rst_pin_test_voltage_in,
    input  wire logic        irq_pin_test_voltage_in,
    input  wire logic        stop_in,
    input  wire logic        internal_reset_in,
    input  wire logic        rst_pin_in,
    output logic             rst_pin_out,
    output logic             rst_pin_oe_out,
    output logic             irq_out
);
    localparam int POR_W = $clog2(POR_CYCLES + 1);

    // two-stage synchronisers for the pin-level inputs
    logic [5:0] pin_meta_q;
    logic [5:0] pin_sync_q;
    logic       rst_pin_lvl;
    logic       rate_sel;
    logic       monitor_mode;
    logic       break_state;
    logic       rst_tv;
    logic       irq_tv;

    always_ff @(posedge core_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            // the reset pin idles high through its pull-up, so its stages start high
            pin_meta_q <= 6'h20;
            pin_sync_q <= 6'h20;
        end else begin
            pin_meta_q <= {rst_pin_in, timeout_rate_select_in, monitor_mode_in, break_state_in,
                           rst_pin_test_voltage_in, irq_pin_test_voltage_in};
            pin_sync_q <= pin_meta_q;
        end
    end

    assign rate_sel     = pin_sync_q[4];
    assign monitor_mode = pin_sync_q[3];
    assign break_state  = pin_sync_q[2];
    assign rst_tv       = pin_sync_q[1];
    assign irq_tv       = pin_sync_q[0];
    assign rst_pin_lvl  = pin_sync_q[5];

    // address phase capture; the slave never stretches, so hready is always high
    wdtc_pkg::wdtc_aphase_t aph_q;
    logic                   aph_take;

    assign aph_take = hsel_in && hready_in &&
                      (htrans_in == wdtc_pkg::HTRANS_NONSEQ || htrans_in == wdtc_pkg::HTRANS_SEQ);

    always_ff @(posedge core_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            aph_q <= '0;
        end else begin
            aph_q.valid <= aph_take;
            aph_q.write <= hwrite_in;
            aph_q.addr  <= haddr_in[wdtc_pkg::ADDR_W-1:0];
        end
    end

    function automatic logic hit(input logic [wdtc_pkg::ADDR_W-1:0] a,
                                 input logic [wdtc_pkg::ADDR_W-1:0] reg_addr);
        hit = (a[wdtc_pkg::ADDR_W-1:2] == reg_addr[wdtc_pkg::ADDR_W-1:2]);
    endfunction : hit

    logic rd_take;
    logic svc_wr;
    logic mask_wr;
    logic rd_cause;
    logic rd_status;

    assign rd_take   = aph_take && !hwrite_in;
    assign rd_cause  = rd_take && hit(haddr_in[wdtc_pkg::ADDR_W-1:0], wdtc_pkg::ADDR_CAUSE);
    assign rd_status = rd_take && hit(haddr_in[wdtc_pkg::ADDR_W-1:0], wdtc_pkg::ADDR_IRQ_STATUS);
    // data value is ignored: the write itself is the service
    assign svc_wr    = aph_q.valid && aph_q.write && hit(aph_q.addr, wdtc_pkg::ADDR_SERVICE); // see R3
    assign mask_wr   = aph_q.valid && aph_q.write && hit(aph_q.addr, wdtc_pkg::ADDR_IRQ_MASK);

    // control state
    wdtc_pkg::wdtc_state_t state_q;
    logic [POR_W-1:0]      por_cnt_q;
    logic [4:0]            pulse_cnt_q;
    logic [wdtc_pkg::PRE_W-1:0] pre_q;
    logic [wdtc_pkg::WD_W-1:0]  wd_q;
    logic [17:0]           chain;
    logic                  disabled;
    logic                  timeout;
    logic                  por_clear;
    logic                  int_reset;
    logic                  in_pulse;

    assign chain     = {wd_q, pre_q};
    // either test voltage in monitor state, or the reset-pin test voltage in break state, keeps the watchdog quiet
    assign disabled  = (monitor_mode && (rst_tv || irq_tv)) || (break_state && rst_tv); // see R6
    // rate select only chooses the compare, the count is untouched
    assign timeout   = (state_q == wdtc_pkg::WDTC_ST_RUN) && !disabled &&
                       (rate_sel ? (chain[12:0] == (wdtc_pkg::SHORT_TIMEOUT[12:0] - 13'h0001))
                                 : (chain == (wdtc_pkg::LONG_TIMEOUT - 18'h00001))); // see R2 R12
    assign por_clear = (state_q == wdtc_pkg::WDTC_ST_POR) && (por_cnt_q == POR_W'(POR_CYCLES - 1));
    assign int_reset = internal_reset_in || timeout;
    assign in_pulse  = (state_q == wdtc_pkg::WDTC_ST_PULSE);

    // power-on window counter, only advances while the window is open
    always_ff @(posedge core_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            por_cnt_q <= '0;
        end else if (state_q == wdtc_pkg::WDTC_ST_POR) begin
            por_cnt_q <= por_cnt_q + POR_W'(1);
        end
    end

    // reset pulse counter, restarts from zero on every pulse
    always_ff @(posedge core_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            pulse_cnt_q <= 5'h00;
        end else if (in_pulse) begin
            pulse_cnt_q <= pulse_cnt_q + 5'h01;
        end else begin
            pulse_cnt_q <= 5'h00;
        end
    end

    // power-on window, then counting, then the reset pulse and back to counting
    always_ff @(posedge core_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            state_q <= wdtc_pkg::WDTC_ST_POR;
        end else begin
            case (state_q)
                wdtc_pkg::WDTC_ST_POR: begin
                    if (por_clear) begin
                        state_q <= wdtc_pkg::WDTC_ST_RUN; // see R8
                    end
                end
                wdtc_pkg::WDTC_ST_RUN: begin
                    if (timeout) begin
                        state_q <= wdtc_pkg::WDTC_ST_PULSE;
                    end
                end
                wdtc_pkg::WDTC_ST_PULSE: begin
                    if (pulse_cnt_q == 5'(wdtc_pkg::RST_PULSE_CYC - 1)) begin
                        state_q <= wdtc_pkg::WDTC_ST_RUN; // see R5
                    end
                end
                default: begin
                    state_q <= wdtc_pkg::WDTC_ST_POR;
                end
            endcase
        end
    end

    // prescaler, one step per oscillator cycle
    always_ff @(posedge core_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            pre_q <= '0;
        end else if (int_reset || in_pulse) begin
            pre_q <= '0; // see R9
        end else if (por_clear || stop_in) begin
            pre_q <= '0; // see R7 R8
        end else if (svc_wr) begin
            // low prescaler stages keep running, which is why a full timeout is 16 short of 2^18
            pre_q[wdtc_pkg::SVC_CLR_HI:wdtc_pkg::SVC_CLR_LO] <= '0; // see R3
            if (!disabled) begin
                pre_q[wdtc_pkg::SVC_CLR_LO-1:0] <= pre_q[wdtc_pkg::SVC_CLR_LO-1:0] + wdtc_pkg::SVC_CLR_LO'(1);
            end
        end else if (!disabled) begin
            pre_q <= pre_q + wdtc_pkg::PRE_W'(1); // see R1 R10
        end
    end

    // watchdog counter, stepped by the prescaler carry
    always_ff @(posedge core_clk_in or negedge arst_n_in) begin
        // a service is never lost, even in a cycle that also clears the prescaler
        if (!arst_n_in) begin
            wd_q <= '0;
        end else if (int_reset || in_pulse || svc_wr) begin
            wd_q <= '0; // see R3 R9
        end else if (!por_clear && !stop_in && !disabled && (&pre_q)) begin
            wd_q <= wd_q + wdtc_pkg::WD_W'(1); // see R1
        end
    end

    // open-drain reset pin, low while the pulse state lasts
    always_ff @(posedge core_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            rst_pin_oe_out <= 1'b0;
            rst_pin_out    <= 1'b0;
        end else begin
            rst_pin_oe_out <= timeout || (state_q == wdtc_pkg::WDTC_ST_PULSE &&
                              pulse_cnt_q != 5'(wdtc_pkg::RST_PULSE_CYC - 1)); // see R5
            rst_pin_out    <= 1'b0;
        end
    end

    // cause flag and interrupt status: set wins over the read that clears
    logic [1:0] cause_q;
    logic [1:0] status_q;
    logic [1:0] mask_q;
    logic [1:0] events;

    assign events = {svc_wr, timeout};

    always_ff @(posedge core_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            cause_q <= wdtc_pkg::EVT_RESET;
        end else begin
            cause_q <= (rd_cause ? 2'h0 : cause_q) | {1'b0, timeout}; // see R5
        end
    end

    always_ff @(posedge core_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            status_q <= wdtc_pkg::EVT_RESET;
        end else begin
            status_q <= (rd_status ? 2'h0 : status_q) | events;
        end
    end

    always_ff @(posedge core_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            mask_q <= wdtc_pkg::MASK_RESET;
        end else if (mask_wr) begin
            mask_q <= hwdata_in[1:0];
        end
    end

    always_ff @(posedge core_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            irq_out <= 1'b0;
        end else begin
            irq_out <= |(status_q & mask_q);
        end
    end

    // read data is registered at the address phase so it stands in the data phase
    logic [31:0] rdata;
    logic [19:0] ra;

    always_comb begin
        ra    = haddr_in[wdtc_pkg::ADDR_W-1:0];
        rdata = 32'h0000_0000;
        if (hit(ra, wdtc_pkg::ADDR_SERVICE)) begin
            rdata = {24'h000000, VECTOR_LO}; // see R4
        end else if (hit(ra, wdtc_pkg::ADDR_CAUSE)) begin
            rdata = {30'h0, cause_q};
        end else if (hit(ra, wdtc_pkg::ADDR_IRQ_STATUS)) begin
            rdata = {30'h0, status_q};
        end else if (hit(ra, wdtc_pkg::ADDR_IRQ_MASK)) begin
            rdata = {30'h0, mask_q};
        end else if (hit(ra, wdtc_pkg::ADDR_COUNT)) begin
            rdata = {rst_pin_lvl, 11'h000, disabled, rate_sel, chain};
        end
    end

    always_ff @(posedge core_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            hrdata_out    <= 32'h0000_0000;
            hreadyout_out <= 1'b1;
            hresp_out     <= 1'b0;
        end else begin
            hrdata_out    <= rd_take ? rdata : 32'h0000_0000;
            hreadyout_out <= 1'b1;
            hresp_out     <= 1'b0;
        end
    end

    logic unused_ok;
    assign unused_ok = &{1'b0, hsize_in, haddr_in[31:wdtc_pkg::ADDR_W], hwdata_in[31:2]};
endmodule : wdtc_top
`default_nettype wire

// >>> verification/wdtc_asserts.sv
// Purpose: port-level assertions for the watchdog timeout counter
// Assumes: one clock domain, asynchronous active-low reset
// Notes:   reset pulse length is counted in helper logic
`default_nettype none
module wdtc_checker #(
    parameter logic [7:0] VECTOR_LO = 8'h00
) (
    input wire logic        core_clk_in,
    input wire logic        arst_n_in,
    input wire logic        hsel_in,
    input wire logic [31:0] haddr_in,
    input wire logic [1:0]  htrans_in,
    input wire logic        hwrite_in,
    input wire logic        hready_in,
    input wire logic [31:0] hrdata_out,
    input wire logic        hreadyout_out,
    input wire logic        hresp_out,
    input wire logic        monitor_mode_in,
    input wire logic        rst_pin_test_voltage_in,
    input wire logic        rst_pin_out,
    input wire logic        rst_pin_oe_out
);
    logic [7:0] oe_cnt_q;
    logic [7:0] oe_cnt_d;
    assign oe_cnt_d = rst_pin_oe_out ? oe_cnt_q + 8'h01 : 8'h00;
    always_ff @(posedge core_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) oe_cnt_q <= 8'h00;
        else oe_cnt_q <= oe_cnt_d;
    end
    default clocking @(posedge core_clk_in); endclocking
    default disable iff (!arst_n_in);
    sequence rd_s; hsel_in && hready_in && htrans_in[1] && !hwrite_in; endsequence
    sequence svc_rd_s; rd_s ##0 (haddr_in[19:0] == wdtc_pkg::ADDR_SERVICE); endsequence
    sequence hole_rd_s; rd_s ##0 (haddr_in[19:0] == 20'h00100); endsequence
    bus_okay_a:
        assert property (hreadyout_out && !hresp_out) else $error("bus not ready or not okay");
    pin_low_a:
        assert property (rst_pin_out == 1'b0) else $error("reset pin drive level not low");
    svc_read_a:
        assert property (svc_rd_s |=> hrdata_out[7:0] == VECTOR_LO) else $error("service read not vector");
    hole_read_a:
        assert property (hole_rd_s |=> hrdata_out == 32'h0) else $error("unmapped read not zero");
    idle_data_a:
        assert property (!(hsel_in && hready_in && htrans_in[1] && !hwrite_in) |=> hrdata_out == 32'h0)
            else $error("read data outside data phase");
    pulse_len_a:
        assert property ($fell(rst_pin_oe_out) |-> oe_cnt_q == 8'd32) else $error("reset pulse length wrong");
    pulse_cap_a:
        assert property (oe_cnt_q <= 8'd32) else $error("reset pulse too long");
    pulse_gap_a:
        assert property ($fell(rst_pin_oe_out) |-> !rst_pin_oe_out [*8]) else $error("pulse restarted");
    test_hold_a:
        assert property ((monitor_mode_in && rst_pin_test_voltage_in) [*5] |-> !$rose(rst_pin_oe_out))
            else $error("timeout while disabled");
endmodule : wdtc_checker
bind wdtc_top wdtc_checker #(.VECTOR_LO(VECTOR_LO)) wdtc_checker_i (
    .core_clk_in(core_clk_in), .arst_n_in(arst_n_in), .hsel_in(hsel_in), .haddr_in(haddr_in),
    .htrans_in(htrans_in), .hwrite_in(hwrite_in), .hready_in(hready_in), .hrdata_out(hrdata_out),
    .hreadyout_out(hreadyout_out), .hresp_out(hresp_out), .monitor_mode_in(monitor_mode_in),
    .rst_pin_test_voltage_in(rst_pin_test_voltage_in), .rst_pin_out(rst_pin_out),
    .rst_pin_oe_out(rst_pin_oe_out));
`default_nettype wire

// >>> verification/wdtc_top_tb.sv
// Purpose: self-checking bench for the watchdog timeout counter
// Assumes: power-on window shortened to 8 cycles
// Notes:   long timeout only checked as absent; it would exceed the run
`default_nettype none
module wdtc_top_tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [31:0] A_SVC = 32'(wdtc_pkg::ADDR_SERVICE);
    localparam logic [31:0] A_CAU = 32'(wdtc_pkg::ADDR_CAUSE);
    localparam logic [31:0] A_STA = 32'(wdtc_pkg::ADDR_IRQ_STATUS);
    localparam logic [31:0] A_MSK = 32'(wdtc_pkg::ADDR_IRQ_MASK);
    localparam logic [31:0] A_CNT = 32'(wdtc_pkg::ADDR_COUNT);
    logic        clk = 0, rst_n = 0, hsel = 0, hwrite = 0, rate = 0, mon = 0, brk = 0, rtv = 0, itv = 0;
    logic        stop = 0, irst = 0;
    logic [31:0] haddr = 0, hwdata = 0;
    logic [1:0]  htrans = 0;
    wire logic [31:0] hrdata;
    wire logic        hreadyout, hresp, pin_out, oe, irq, pin;
    int          n_errors = 0, samples_checked = 0, cycles = 0;
    // open-drain reset pin with pull-up
    assign pin = oe ? pin_out : 1'b1;
    wdtc_top #(.POR_CYCLES(8), .VECTOR_LO(8'ha5)) wdtc_top_i (
        .core_clk_in(clk), .arst_n_in(rst_n), .hsel_in(hsel), .haddr_in(haddr), .htrans_in(htrans),
        .hwrite_in(hwrite), .hsize_in(3'h2), .hwdata_in(hwdata), .hready_in(hreadyout), .hrdata_out(hrdata),
        .hreadyout_out(hreadyout), .hresp_out(hresp), .timeout_rate_select_in(rate), .monitor_mode_in(mon),
        .break_state_in(brk), .rst_pin_test_voltage_in(rtv), .irq_pin_test_voltage_in(itv), .stop_in(stop),
        .internal_reset_in(irst), .rst_pin_in(pin), .rst_pin_out(pin_out), .rst_pin_oe_out(oe), .irq_out(irq));
    always #5 clk = ~clk;
    task automatic close_out();
        $display("checked %0d errors %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : close_out
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        samples_checked++;
        if (got !== exp) begin
            n_errors++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task automatic cyc(input int k);
        repeat (k) @(posedge clk);
    endtask : cyc
    // entered just after a rising edge; address phase then data phase
    task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] d, output logic [31:0] r);
        hsel <= 1'b1; htrans <= wdtc_pkg::HTRANS_NONSEQ; haddr <= a; hwrite <= wr;
        do @(posedge clk); while (hreadyout !== 1'b1);
        hsel <= 1'b0; htrans <= 2'h0; hwdata <= d;
        do @(posedge clk); while (hreadyout !== 1'b1);
        r = hrdata;
    endtask : ahb
    task automatic rd(input logic [31:0] a, output logic [31:0] r);
        ahb(1'b0, a, 32'h0, r);
    endtask : rd
    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        logic [31:0] r;
        ahb(1'b1, a, d, r);
    endtask : wr
    task automatic t_regs();
        logic [31:0] r;
        rd(A_CAU, r); chk("cause", 32'h0, r);
        rd(A_STA, r); chk("status", 32'h0, r);
        wr(A_MSK, 32'h3); rd(A_MSK, r); chk("mask", 32'h3, r);
        wr(A_MSK, 32'h0);
        rd(A_SVC, r); chk("vector", 32'h000000a5, r);
        rd(32'h100, r); chk("hole", 32'h0, r);
    endtask : t_regs
    task automatic t_timeout();
        logic [31:0] r;
        int          n;
        n = 0;
        repeat (8300) begin @(posedge clk); if (oe !== 1'b0) n++; end
        chk("long_quiet", 32'h0, n);
        rate <= 1'b1; cyc(4); wr(A_SVC, 32'h0);
        n = 0;
        while (oe !== 1'b1 && n < 9000) begin @(posedge clk); n++; end
        chk("short_wait", 32'h1, 32'(n >= 8150 && n <= 8180));
        rate <= 1'b0;
        n = 0;
        while (oe === 1'b1 && n < 50) begin @(posedge clk); n++; end
        chk("pulse", 32'd32, n);
        rd(A_CAU, r); chk("cause", 32'h1, r);
        rd(A_CAU, r); chk("cause_clr", 32'h0, r);
        rd(A_STA, r); chk("status", 32'h3, r);
    endtask : t_timeout
    task automatic t_irq();
        logic [31:0] r;
        rd(A_STA, r); wr(A_MSK, 32'h2); wr(A_SVC, 32'h0); cyc(3);
        chk("irq", 32'h1, 32'(irq));
        rd(A_STA, r); chk("status", 32'h2, r); cyc(3);
        chk("irq_clr", 32'h0, 32'(irq));
        wr(A_MSK, 32'h1); wr(A_SVC, 32'h0); cyc(3);
        chk("irq_masked", 32'h0, 32'(irq));
        rd(A_STA, r); chk("status", 32'h2, r);
    endtask : t_irq
    task automatic t_clear();
        logic [31:0] r;
        cyc(4200); wr(A_SVC, 32'h0); rd(A_CNT, r);
        chk("svc_clear", 32'h1, 32'(r[17:0] < 18'd32));
        chk("pin_idle", 32'h1, 32'(r[31]));
        cyc(4200); stop <= 1'b1; cyc(1); stop <= 1'b0; rd(A_CNT, r);
        chk("stop_wd", 32'h1, 32'(r[17:12]));
        chk("stop_pre", 32'h1, 32'(r[11:0] < 12'd8));
        irst <= 1'b1; cyc(1); irst <= 1'b0; rd(A_CNT, r);
        chk("int_reset", 32'h1, 32'(r[17:0] < 18'd8));
    endtask : t_clear
    task automatic t_dis();
        logic [31:0] a, b;
        logic [3:0]  m [4] = '{4'b1010, 4'b1001, 4'b0110, 4'b0101};
        for (int i = 0; i < 4; i++) begin
            {mon, brk, rtv, itv} <= m[i]; cyc(4);
            rd(A_CNT, a); cyc(20); rd(A_CNT, b);
            chk("hold", 32'(i < 3), 32'(a[17:0] === b[17:0]));
            chk("dis_bit", 32'(i < 3), 32'(b[19]));
            {mon, brk, rtv, itv} <= 4'h0; cyc(4);
        end
    endtask : t_dis
    // hang guard: the whole sequence needs about 25000 cycles
    always @(posedge clk) begin
        cycles++;
        if (cycles == 40000) begin n_errors++; close_out(); end
    end
    initial begin
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        cyc(12);
        t_regs(); t_timeout(); t_irq(); t_clear(); t_dis();
        close_out();
    end
endmodule : wdtc_top_tb
`default_nettype wire
